// ---- bench/counter_array_watchdog_asserts.sv ----
// assertion checker for the counter array watchdog
`timescale 1ns/10ps
module counter_array_watchdog_asserts #(
    parameter DATA_W = 8
) (
    input wire              CLK_I,
    input wire              RST_I,
    input wire [7:0]        ADDR_I,
    input wire [DATA_W-1:0] WDATA_I,
    input wire              WR_I,
    input wire              RD_I,
    input wire              IDLE_I,
    input wire              EXT_TICK_I,
    input wire [4:0]        CH_MATCH_I,
    input wire [DATA_W-1:0] RDATA_O,
    input wire              WD_RESET_O,
    input wire              IRQ_O,
    input wire [15:0]       COUNT_O
);
    reg       lock;
    reg       en;
    reg       run;
    reg       idl;
    reg [2:0] src;
    wire      wd_on = en | lock;
    // shadow of the software-visible mode and run state
    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            lock <= 1'b0;
            en <= 1'b1;
            run <= 1'b0;
            idl <= 1'b0;
            src <= 3'h0;
        end else if (WR_I && ADDR_I == 8'hd9) begin
            lock <= lock | WDATA_I[5];
            if (!lock) en <= WDATA_I[6];
            if (!wd_on) src <= WDATA_I[3:1];
            if (!wd_on) idl <= WDATA_I[7];
        end else if (WR_I && ADDR_I == 8'hd8) begin
            run <= WDATA_I[6];
        end
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    wd_pulse_a: assert property (WD_RESET_O |=> !WD_RESET_O)
        else $error("reset request held too long");
    force_reset_a: assert property (WR_I && ADDR_I == 8'hd8 && WDATA_I[5]
        && wd_on |-> ##[1:2] WD_RESET_O)
        else $error("forced reset missing");
    reset_cause_a: assert property (WD_RESET_O |-> $past(wd_on))
        else $error("reset request while watchdog off");
    irq_match_a: assert property (CH_MATCH_I != 5'h00 |-> ##[1:3] IRQ_O)
        else $error("match did not raise interrupt");
    count_stop_a: assert property ((!wd_on && !run && !WR_I) [*5]
        |-> $stable(COUNT_O))
        else $error("stopped counter moved");
    mode_frozen_a: assert property (RD_I && ADDR_I == 8'hd9
        |=> RDATA_O[3:1] == src && RDATA_O[7] == idl)
        else $error("clock source or idle bit changed");
    lock_read_a: assert property (RD_I && ADDR_I == 8'hd9 |=>
        RDATA_O[5] == $past(lock))
        else $error("lock bit lost");
    run_read_a: assert property (RD_I && ADDR_I == 8'hd8 |=>
        RDATA_O[6] == $past(run))
        else $error("run bit does not read as written");
    cover property (WD_RESET_O);
    cover property (WR_I && ADDR_I == 8'hd8 && WDATA_I[5] && wd_on);
    cover property (CH_MATCH_I != 5'h00);
endmodule // counter_array_watchdog_asserts
bind counter_array_watchdog counter_array_watchdog_asserts #(
    .DATA_W(DATA_W)
) counter_array_watchdog_asserts_i (.CLK_I(CLK_I), .RST_I(RST_I),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
    .IDLE_I(IDLE_I), .EXT_TICK_I(EXT_TICK_I), .CH_MATCH_I(CH_MATCH_I),
    .RDATA_O(RDATA_O), .WD_RESET_O(WD_RESET_O), .IRQ_O(IRQ_O),
    .COUNT_O(COUNT_O));

// ---- bench/counter_array_watchdog_tb.sv ----
// self-checking bench for the counter array watchdog
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
    num_errors++; $display("wrong value at %0t: %h %h", $time, a, b); end end
module counter_array_watchdog_tb;
    reg         CLK_I = 0;
    reg         RST_I = 1;
    reg  [7:0]  ADDR_I = 0;
    reg  [7:0]  WDATA_I = 0;
    reg         WR_I = 0;
    reg         RD_I = 0;
    reg  [4:0]  CH_MATCH_I = 0;
    reg         IDLE_I = 0;
    reg         EXT_TICK_I = 0;
    wire [7:0]  RDATA_O;
    wire        WD_RESET_O;
    wire        IRQ_O;
    wire [15:0] COUNT_O;
    int         num_errors = 0;
    int         check_count = 0;
    int         n;
    reg  [15:0] c;
    counter_array_watchdog counter_array_watchdog_i (.CLK_I(CLK_I),
        .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
        .RD_I(RD_I), .IDLE_I(IDLE_I), .EXT_TICK_I(EXT_TICK_I),
        .CH_MATCH_I(CH_MATCH_I), .RDATA_O(RDATA_O),
        .WD_RESET_O(WD_RESET_O), .IRQ_O(IRQ_O), .COUNT_O(COUNT_O));
    initial begin
        forever #20 CLK_I = ~CLK_I;
    end
    task wr(input [7:0] a, input [7:0] d);
        ADDR_I = a;
        WDATA_I = d;
        WR_I = 1;
        @(posedge CLK_I) #1 WR_I = 0;
    endtask
    task rd(input [7:0] a, input [7:0] e);
        ADDR_I = a;
        RD_I = 1;
        @(posedge CLK_I) #1 RD_I = 0;
        `CHK(RDATA_O, e)
    endtask
    // counts cycles up to the next reset request, bounded
    task wait_wd();
        n = 0;
        while (WD_RESET_O !== 1'b1 && n < 5000) begin
            @(posedge CLK_I) #1 n++;
        end
    endtask
    task give_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #(40 * 30000);
        num_errors++;
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge CLK_I);
        #1 RST_I = 0;
        rd(8'hd9, 8'h40);
        rd(8'hd8, 8'h00);
        wr(8'hf9, 8'hab);
        `CHK(COUNT_O[15:8] == 8'hab, 1'b0)
        wait_wd();
        `CHK(n > 3050 && n < 3100, 1'b1)
        wr(8'hd9, 8'h00);
        rd(8'hd9, 8'h00);
        c = COUNT_O;
        repeat (20) @(posedge CLK_I);
        #1 `CHK(COUNT_O, c)
        wr(8'he9, 8'hfe);
        wr(8'hf9, 8'hff);
        wr(8'hd9, 8'h08);
        wr(8'hd8, 8'h40);
        repeat (8) @(posedge CLK_I);
        #1 rd(8'hd8, 8'hc0);
        CH_MATCH_I = 5'h04;
        @(posedge CLK_I) #1 CH_MATCH_I = 0;
        repeat (2) @(posedge CLK_I);
        #1 rd(8'hd8, 8'hc4);
        `CHK(IRQ_O, 1'b1)
        wr(8'hd8, 8'h00);
        rd(8'hd8, 8'h00);
        wr(8'hd3, 8'h02);
        wr(8'hd9, 8'h48);
        c = COUNT_O;
        wr(8'hd4, 8'hff);
        c[7:0] = COUNT_O[7:0];
        rd(8'hd4, c[15:8] + 8'h02);
        wait_wd();
        `CHK(n + 1 + c[7:0] > 764 && n + 1 + c[7:0] < 772, 1'b1)
        wr(8'hd9, 8'h4e);
        rd(8'hd9, 8'h48);
        c = COUNT_O;
        repeat (4) @(posedge CLK_I);
        #1 `CHK(COUNT_O !== c, 1'b1)
        wr(8'hd8, 8'h40);
        rd(8'hd8, 8'h40);
        wr(8'hd8, 8'h20);
        wait_wd();
        `CHK(n < 3, 1'b1)
        wr(8'hd9, 8'h00);
        wr(8'hd9, 8'h04);
        wr(8'hd8, 8'h40);
        c = COUNT_O;
        repeat (3) begin
            EXT_TICK_I = 1;
            repeat (3) @(posedge CLK_I);
            #1 EXT_TICK_I = 0;
            repeat (3) @(posedge CLK_I);
            #1;
        end
        repeat (6) @(posedge CLK_I);
        #1 `CHK(COUNT_O, c + 16'h0003)
        wr(8'hd9, 8'h88);
        wr(8'hd9, 8'hc8);
        IDLE_I = 1;
        repeat (4) @(posedge CLK_I);
        #1 c = COUNT_O;
        repeat (8) @(posedge CLK_I);
        #1 `CHK(COUNT_O, c)
        IDLE_I = 0;
        repeat (4) @(posedge CLK_I);
        #1 `CHK(COUNT_O !== c, 1'b1)
        RST_I = 1;
        @(posedge CLK_I) #1 RST_I = 0;
        wr(8'hd9, 8'h00);
        wr(8'hd9, 8'h20);
        wr(8'hd9, 8'h00);
        rd(8'hd9, 8'h20);
        wr(8'hd8, 8'h20);
        wait_wd();
        `CHK(n < 3, 1'b1)
        give_verdict();
    end
endmodule // counter_array_watchdog_tb

// ---- hw/counter_array_watchdog.v ----
// watchdog on channel 5 of the counter array, with control/flag register
// Function
// - watchdog enabled keeps the counter running whatever the run bit says, except while idle suspend is set and idle is high
// - counter byte writes are ignored while watchdog is enabled
// - clock source select and idle suspend frozen while watchdog enabled
// - channel 5 forced to software timer, its mode writes ignored while watchdog enabled
// - run bit writes do not change counting while watchdog enabled
// - run bit reads zero unless software set it
// - reset when low byte overflows while channel 5 high equals count high
// - channel 5 high write loads count high plus channel 5 offset
// - timeout is 256 times offset plus 256 minus low byte
// - writing 1 to channel 5 flag with watchdog on forces reset
// - enable bit or lock bit enables the watchdog
// - lock bit keeps watchdog enabled until next system reset
// - without lock, clearing enable bit disables the watchdog
// - after reset watchdog on, divide by 12, low byte and offset zero
// - overflow flag set on 16-bit wrap, interrupt if enabled, sticky
// - run bit at bit 6 starts and stops the counter outside watchdog
// - compare flags set on channel match (channel 5 only while watchdog off), always interrupt (no enable bit), sticky
`timescale 1ns/10ps
`include "counter_array_watchdog_defs.vh"

module counter_array_watchdog #(
    parameter DATA_W = 8
) (
    input  wire              CLK_I,
    input  wire              RST_I,
    input  wire [7:0]        ADDR_I,
    input  wire [DATA_W-1:0] WDATA_I,
    input  wire              WR_I,
    input  wire              RD_I,
    input  wire              IDLE_I,
    input  wire              EXT_TICK_I,
    input  wire [4:0]        CH_MATCH_I,
    output reg  [DATA_W-1:0] RDATA_O,
    output reg               WD_RESET_O,
    output reg               IRQ_O,
    output reg  [15:0]       COUNT_O
);

    reg  [7:0] count_low;
    reg  [7:0] count_high;
    reg        overflow_flag;
    reg        run_bit;
    wire [5:0] compare_flags;
    reg        idle_suspend;
    reg        wd_enable;
    reg        wd_lock;
    reg  [2:0] clock_source;
    reg        ovf_int_en;
    reg  [7:0] ch5_mode;
    reg  [7:0] ch5_offset;
    reg  [7:0] ch5_high;
    reg  [3:0] prescale;
    reg        tick_meta;
    reg        tick_sync;
    reg        tick_last;
    reg        idle_meta;
    reg        idle_sync;
    reg        tick;
    reg        next_wd_reset;
    reg  [DATA_W-1:0] next_rdata;

    wire       wd_on      = wd_enable | wd_lock;
    wire       wr_ctl     = WR_I && (ADDR_I == `ADDR_CONTROL_FLAGS);
    wire       wr_mode    = WR_I && (ADDR_I == `ADDR_MODE_REG);
    wire       wr_low     = WR_I && (ADDR_I == `ADDR_COUNT_LOW);
    wire       wr_high    = WR_I && (ADDR_I == `ADDR_COUNT_HIGH);
    // channel 5 strobes
    wire       wr_ch5_mode   = WR_I && (ADDR_I == `ADDR_CH5_MODE);
    wire       wr_ch5_offset = WR_I && (ADDR_I == `ADDR_CH5_OFFSET);
    wire       wr_ch5_high   = WR_I && (ADDR_I == `ADDR_CH5_HIGH);
    // bit 4 of the mode register reads zero
    wire [7:0] mode_read  = {idle_suspend, wd_enable, wd_lock, 1'b0,
                             clock_source, ovf_int_en};
    wire       counting   = (run_bit | wd_on) & ~(idle_suspend & idle_sync);
    wire       advance    = counting & tick;
    wire       low_wrap   = advance & (count_low == 8'hff);
    wire       full_wrap  = low_wrap & (count_high == 8'hff);
    wire [7:0] low_next   = count_low + 8'h01;
    wire [7:0] high_next  = count_high + 8'h01;
    wire [5:0] ctl_wdata  = WDATA_I[`BIT_FLAGS_HI:0];
    wire [7:0] ch5_eff    = wd_on ? `CH5_SW_TIMER_MODE : ch5_mode;
    wire       ch5_match  = ch5_eff[`CH5_MATCH_BIT] & ch5_eff[`CH5_ECOM_BIT]
                          & advance & (ch5_high == count_high)
                          & (ch5_offset == count_low);
    wire [5:0] match_set  = {ch5_match & ~wd_on, CH_MATCH_I};

    // external tick passes two flip-flops before its edge is read
    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            tick_meta <= 1'b0;
            tick_sync <= 1'b0;
            tick_last <= 1'b0;
        end else begin
            tick_meta <= EXT_TICK_I;
            tick_sync <= tick_meta;
            tick_last <= tick_sync;
        end
    end

    // idle level is asynchronous too; two stages before it pauses counting
    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            idle_meta <= 1'b0;
            idle_sync <= 1'b0;
        end else begin
            idle_meta <= IDLE_I;
            idle_sync <= idle_meta;
        end
    end

    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            prescale <= 4'h0;
            tick     <= 1'b0;
        end else begin
            tick <= 1'b0;
            case (clock_source)
                `SRC_DIV12: begin
                    if (prescale >= `DIV12_LAST) begin
                        prescale <= 4'h0;
                        tick     <= 1'b1;
                    end else begin
                        prescale <= prescale + 4'h1;
                    end
                end
                `SRC_DIV4: begin
                    if (prescale >= `DIV4_LAST) begin
                        prescale <= 4'h0;
                        tick     <= 1'b1;
                    end else begin
                        prescale <= prescale + 4'h1;
                    end
                end
                `SRC_EXT_TICK: begin
                    prescale <= 4'h0;
                    tick     <= tick_sync & ~tick_last;
                end
                `SRC_SYSCLK: begin
                    prescale <= 4'h0;
                    tick     <= 1'b1;
                end
                default: begin
                    prescale <= 4'h0;
                    tick     <= 1'b0;
                end
            endcase
        end
    end

    // counter; byte writes locked out while watchdog on
    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            count_low  <= `RST_BYTE;
            count_high <= `RST_BYTE;
        end else begin
            if (wr_low && !wd_on) begin
                count_low <= WDATA_I[7:0];
            end else if (advance) begin
                count_low <= low_next;
            end
            // high byte steps only on a low wrap
            if (wr_high && !wd_on) begin
                count_high <= WDATA_I[7:0];
            end else if (low_wrap) begin
                count_high <= high_next;
            end
        end
    end

    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            overflow_flag <= 1'b0;
        end else if (full_wrap) begin
            overflow_flag <= 1'b1;
        end else if (wr_ctl) begin
            overflow_flag <= WDATA_I[`BIT_OVERFLOW_FLAG];
        end
    end

    // run bit kept as written, so it reads zero
    // until software sets it, even while the watchdog forces counting
    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            run_bit <= 1'b0;
        end else if (wr_ctl) begin
            run_bit <= WDATA_I[`BIT_COUNTER_RUN];
        end
    end

    // sticky compare flags, one per channel, set beats clear
    genvar ch;
    generate
        for (ch = 0; ch < `FLAG_COUNT; ch = ch + 1) begin : flag_bit
            reg flag;
            always @(posedge CLK_I or posedge RST_I) begin
                if (RST_I) begin
                    flag <= 1'b0;
                end else if (match_set[ch]) begin
                    flag <= 1'b1;
                end else if (wr_ctl) begin
                    flag <= ctl_wdata[ch];
                end
            end
            assign compare_flags[ch] = flag;
        end
    endgenerate

    // mode register
    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            idle_suspend <= 1'b0;
            wd_enable    <= 1'b1;
            wd_lock      <= 1'b0;
            clock_source <= `SRC_DIV12;
            ovf_int_en   <= 1'b0;
        end else if (wr_mode) begin
            ovf_int_en <= WDATA_I[`BIT_OVF_INT_EN];
            // lock sticks, enable clears only unlocked
            if (!wd_lock) begin
                wd_enable <= WDATA_I[`BIT_WD_ENABLE];
            end
            wd_lock <= wd_lock | WDATA_I[`BIT_WD_LOCK];
            if (!wd_on) begin
                idle_suspend <= WDATA_I[`BIT_IDLE_SUSPEND];
                clock_source <= WDATA_I[`SRC_FIELD_HI:`SRC_FIELD_LO];
            end
        end
    end

    // channel 5 registers
    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ch5_mode   <= `RST_BYTE;
            ch5_offset <= `RST_BYTE;
            ch5_high   <= `RST_BYTE;
        end else begin
            if (wr_ch5_mode && !wd_on) begin
                ch5_mode <= WDATA_I[7:0];
            end
            // offset may change while enabled; the next refresh uses it
            if (wr_ch5_offset) begin
                ch5_offset <= WDATA_I[7:0];
            end
            // refresh drops the written value, loads high plus offset
            if (wr_ch5_high) begin
                ch5_high <= count_high + ch5_offset;
            end
        end
    end

    // both causes merge into one registered pulse
    always @* begin
        next_wd_reset = wd_on & low_wrap & (ch5_high == count_high);
        if (wr_ctl && wd_on && WDATA_I[`BIT_CH5_FLAG]) begin
            next_wd_reset = 1'b1;
        end
    end

    // read mux; unmapped addresses read zero
    always @* begin
        case (ADDR_I)
            `ADDR_CONTROL_FLAGS: next_rdata = {overflow_flag, run_bit,
                                               compare_flags};
            `ADDR_MODE_REG:      next_rdata = mode_read;
            `ADDR_COUNT_LOW:     next_rdata = count_low;
            `ADDR_COUNT_HIGH:    next_rdata = count_high;
            `ADDR_CH5_MODE:      next_rdata = ch5_eff;
            `ADDR_CH5_OFFSET:    next_rdata = ch5_offset;
            `ADDR_CH5_HIGH:      next_rdata = ch5_high;
            default:             next_rdata = {DATA_W{1'b0}};
        endcase
    end

    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            WD_RESET_O <= 1'b0;
            IRQ_O      <= 1'b0;
            COUNT_O    <= 16'h0000;
            RDATA_O    <= {DATA_W{1'b0}};
        end else begin
            WD_RESET_O <= next_wd_reset;
            IRQ_O      <= (overflow_flag & ovf_int_en) | (|compare_flags);
            COUNT_O    <= {count_high, count_low};
            // read data stands until the next read strobe
            if (RD_I) begin
                RDATA_O <= next_rdata;
            end
        end
    end

endmodule // counter_array_watchdog

// ---- hw/counter_array_watchdog_defs.vh ----
// register addresses, field positions, reset values and counts
`ifndef COUNTER_ARRAY_WATCHDOG_DEFS_VH
`define COUNTER_ARRAY_WATCHDOG_DEFS_VH
`define ADDR_CONTROL_FLAGS   8'hd8
`define ADDR_MODE_REG        8'hd9
`define ADDR_COUNT_LOW       8'he9
`define ADDR_COUNT_HIGH      8'hf9
`define ADDR_CH5_MODE        8'hce
`define ADDR_CH5_OFFSET      8'hd3
`define ADDR_CH5_HIGH        8'hd4
`define BIT_OVERFLOW_FLAG    7
`define BIT_COUNTER_RUN      6
`define BIT_CH5_FLAG         5
`define BIT_IDLE_SUSPEND     7
`define BIT_WD_ENABLE        6
`define BIT_WD_LOCK          5
`define BIT_OVF_INT_EN       0
`define SRC_FIELD_HI         3
`define SRC_FIELD_LO         1
`define BIT_FLAGS_HI         5
`define FLAG_COUNT           6
`define CH5_ECOM_BIT         6
`define CH5_MATCH_BIT        3
`define RST_CONTROL_FLAGS    8'h00
`define RST_MODE_REG         8'h40
`define RST_BYTE             8'h00
`define CH5_SW_TIMER_MODE    8'h48
`define SRC_DIV12            3'h0
`define SRC_DIV4             3'h1
`define SRC_EXT_TICK         3'h2
`define SRC_SYSCLK           3'h4
`define DIV12_LAST           4'hb
`define DIV4_LAST            4'h3
`endif
